// [link_pkg.sv]
// Purpose: Shared constants and types for the nibble link port set
// Assumes: Core clock of 200 MHz; link words of 32 or 48 bits
// Notes:   Times are in ns; cycle counts derive from them
package link_pkg;

  localparam int NPORTS_DEF   = 6;
  localparam int NIB_W        = 4;
  localparam int BYTE_W       = 8;
  localparam int WORD_W       = 48;
  localparam int NARROW_W     = 32;
  localparam int BYTES_NARROW = NARROW_W / BYTE_W;
  localparam int BYTES_WIDE   = WORD_W / BYTE_W;
  localparam int NIBS_NARROW  = NARROW_W / NIB_W;
  localparam int NIBS_WIDE    = WORD_W / NIB_W;
  localparam int CNT_W        = 4;

  // Link DMA channel layout
  localparam int DED_DMA_PORTS    = 2;
  localparam int SHARED_DMA_PORTS = 4;

  // Port used when booting from the link
  localparam int BOOT_PORT = 0;

  // Strap pattern that selects link booting
  localparam logic BOOT_LINK_HOST  = 1'b1;
  localparam logic BOOT_EPROM      = 1'b0;
  localparam logic BOOT_MEM_SEL_N  = 1'b1;

  // Timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int LCLK_HALF_NS   = 10;
  localparam int TX_GAP_NS      = 20;
  localparam int LCLK_HALF_CYC  = (LCLK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                  (LCLK_HALF_NS / CLK_PERIOD_NS);
  localparam int TX_GAP_CYC     = ((TX_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                                  ((TX_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int TIMER_W        = 8;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_DRIVE = 3'b010,
    TX_GAP   = 3'b100
  } tx_state_t;

endpackage : link_pkg

// [word_buffer2.sv]
// Purpose: Two-deep word buffer with registered head word
// Assumes: Push and pop on the same clock; pop only while out_valid
// Notes:   Head is a flip-flop, so out_data never comes from logic
`timescale 1ns/1ps
module word_buffer2 #(
  parameter int WIDTH = 48
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import link_pkg::*;

  logic [1:0]       cnt_ff,  nxt_cnt;
  logic [WIDTH-1:0] head_ff, nxt_head;
  logic [WIDTH-1:0] tail_ff, nxt_tail;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;
  assign out_data  = head_ff;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_head = head_ff;
    nxt_tail = tail_ff;
    if (push && pop) begin
      if (cnt_ff == 2'h1) begin
        nxt_head = in_data;
      end else begin
        nxt_head = tail_ff;
        nxt_tail = in_data;
      end
    end else if (push) begin
      nxt_cnt = cnt_ff + 2'h1;
      if (cnt_ff == 2'h0) begin
        nxt_head = in_data;
      end else begin
        nxt_tail = in_data;
      end
    end else if (pop) begin
      nxt_cnt  = cnt_ff - 2'h1;
      nxt_head = tail_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_ff  <= 2'h0;
      head_ff <= '0;
      tail_ff <= '0;
    end else begin
      cnt_ff  <= nxt_cnt;
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
    end
  end

endmodule : word_buffer2

// [nibble_link_port.sv]
// Purpose: Set of independent 4-bit point-to-point link ports
// Assumes: Link clock from a transmitter stands still between words
// Notes:   Receive assembly runs on the incoming link clock
// Operation
// - Each port moves 4-bit nibbles; six ports are provided.
// - Data moves on both link clock edges, one byte per link cycle.
// - Ports run independently and simultaneously without stalling each other.
// - Nibbles pack into 32- or 48-bit words, and words split likewise.
// - Words reachable by direct core access and by DMA.
// - Each port has two-deep receive and two-deep transmit buffers.
// - Clock strobe plus receiver acknowledge pace every transfer.
// - Each port is set individually as transmitter or receiver.
// - Two DMA channels serve links only; four are shared with others.
// - Link boot strap holds one link port in receive until boot_done.
`timescale 1ns/1ps
module nibble_link_port #(
  parameter int NPORTS = link_pkg::NPORTS_DEF
) (
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  input  wire logic [NPORTS-1:0]                     tx_mode,
  input  wire logic [NPORTS-1:0]                     wide_word,
  input  wire logic [NPORTS-1:0]                     lclk_i,
  output logic      [NPORTS-1:0]                     lclk_o,
  output logic      [NPORTS-1:0]                     lclk_oe,
  input  wire logic [NPORTS-1:0][link_pkg::NIB_W-1:0] ldat_i,
  output logic      [NPORTS-1:0][link_pkg::NIB_W-1:0] ldat_o,
  output logic      [NPORTS-1:0]                     ldat_oe,
  input  wire logic [NPORTS-1:0]                     lack_i,
  output logic      [NPORTS-1:0]                     lack_o,
  output logic      [NPORTS-1:0]                     lack_oe,
  output logic      [NPORTS-1:0]                     rx_valid,
  output logic      [NPORTS-1:0][link_pkg::WORD_W-1:0] rx_data,
  input  wire logic [NPORTS-1:0]                     core_rd,
  input  wire logic [NPORTS-1:0]                     dma_rd,
  output logic      [NPORTS-1:0]                     tx_ready,
  input  wire logic [NPORTS-1:0]                     core_wr,
  input  wire logic [NPORTS-1:0][link_pkg::WORD_W-1:0] core_wr_data,
  input  wire logic [NPORTS-1:0]                     dma_wr,
  input  wire logic [NPORTS-1:0][link_pkg::WORD_W-1:0] dma_wr_data,
  input  wire logic [link_pkg::SHARED_DMA_PORTS-1:0] dma_shared_grant,
  input  wire logic                                  link_host_boot_select,
  input  wire logic                                  eprom_boot_select,
  input  wire logic                                  boot_memory_select_n,
  input  wire logic                                  boot_done,
  output logic                                       boot_active
);
  import link_pkg::*;

  if (NPORTS < DED_DMA_PORTS + SHARED_DMA_PORTS || NPORTS <= BOOT_PORT) begin : bad_cfg
    $error("nibble_link_port: NPORTS too small for DMA and boot layout");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot strap capture, taken on the first edge after reset release

  logic capt_ff, nxt_capt;
  logic boot_ff, nxt_boot;

  always_comb begin
    nxt_capt = 1'b1;
    nxt_boot = boot_ff;
    if (!capt_ff) begin
      nxt_boot = (link_host_boot_select == BOOT_LINK_HOST) &&
                 (eprom_boot_select == BOOT_EPROM) &&
                 (boot_memory_select_n == BOOT_MEM_SEL_N);
    end else if (boot_done) begin
      nxt_boot = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      capt_ff <= 1'b0;
      boot_ff <= 1'b0;
    end else begin
      capt_ff <= nxt_capt;
      boot_ff <= nxt_boot;
    end
  end

  assign boot_active = boot_ff;

  function automatic logic dma_allowed(input int p, input logic [SHARED_DMA_PORTS-1:0] g);
    if (p < DED_DMA_PORTS) begin
      return 1'b1;
    end else if (p < DED_DMA_PORTS + SHARED_DMA_PORTS) begin
      return g[p - DED_DMA_PORTS];
    end else begin
      return 1'b0;
    end
  endfunction : dma_allowed

  ////////////////////////////////////////////////////////////////////////////
  // One independent port per iteration

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic is_tx;
    logic rx_en;
    logic dma_ok;

    // Boot forces the boot port to receive
    assign is_tx  = tx_mode[p] & ~(boot_ff && (p == BOOT_PORT));
    assign rx_en  = ~is_tx;
    assign dma_ok = dma_allowed(p, dma_shared_grant);

    //////////////////////////////////////////////////////////////////////////
    // Receive: link clock domain. Nibble on rising edge, byte on falling edge

    logic [NIB_W-1:0]  pos_nib_ff;
    logic              en_s1_ff, en_s2_ff, wide_s1_ff, wide_s2_ff;
    logic [WORD_W-1:0] sh_ff,   nxt_sh;
    logic [CNT_W-1:0]  bcnt_ff, nxt_bcnt;
    logic [WORD_W-1:0] hold_ff, nxt_hold;
    logic              tog_ff,  nxt_tog;

    always_ff @(posedge lclk_i[p]) begin
      pos_nib_ff <= ldat_i[p];
    end

    always_comb begin
      nxt_sh   = {ldat_i[p], pos_nib_ff, sh_ff[WORD_W-1:BYTE_W]};
      nxt_bcnt = bcnt_ff + CNT_W'(1);
      nxt_hold = hold_ff;
      nxt_tog  = tog_ff;
      if (nxt_bcnt == CNT_W'(wide_s2_ff ? BYTES_WIDE : BYTES_NARROW)) begin
        nxt_bcnt = '0;
        nxt_hold = wide_s2_ff ? nxt_sh :
                   {{(WORD_W-NARROW_W){1'b0}}, nxt_sh[WORD_W-1:WORD_W-NARROW_W]};
        nxt_tog  = ~tog_ff;
      end
    end

    always_ff @(negedge lclk_i[p]) begin
      en_s1_ff   <= rx_en & rstn;
      en_s2_ff   <= en_s1_ff;
      wide_s1_ff <= wide_word[p];
      wide_s2_ff <= wide_s1_ff;
      if (!en_s2_ff) begin
        sh_ff   <= '0;
        bcnt_ff <= '0;
        hold_ff <= '0;
        tog_ff  <= 1'b0;
      end else begin
        sh_ff   <= nxt_sh;
        bcnt_ff <= nxt_bcnt;
        hold_ff <= nxt_hold;
        tog_ff  <= nxt_tog;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Receive: core side. Hold word is stable while the toggle crosses

    logic tog_s1_ff, tog_s2_ff, tog_s3_ff;
    logic rx_push;
    logic rx_in_ready;
    logic rx_pop;
    logic rx_pend;

    always_ff @(posedge clk) begin
      if (!rstn) begin
        tog_s1_ff <= 1'b0;
        tog_s2_ff <= 1'b0;
        tog_s3_ff <= 1'b0;
      end else begin
        tog_s1_ff <= tog_ff;
        tog_s2_ff <= tog_s1_ff;
        tog_s3_ff <= tog_s2_ff;
      end
    end

    assign rx_pend = tog_s2_ff ^ tog_s3_ff;
    assign rx_push = rx_pend & rx_en;
    assign rx_pop  = rx_valid[p] & (core_rd[p] | (dma_rd[p] & dma_ok));

    word_buffer2 #(.WIDTH(WORD_W)) u_rx_buf (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (rx_push),
      .in_ready  (rx_in_ready),
      .in_data   (hold_ff),
      .out_valid (rx_valid[p]),
      .out_ready (rx_pop),
      .out_data  (rx_data[p])
    );

    // Ack is withdrawn while a word is still crossing, so the hold word
    // is never overwritten before it is buffered
    logic ack_ff, nxt_ack;
    assign nxt_ack = rx_en & rx_in_ready & ~rx_pend & ~rx_push;

    always_ff @(posedge clk) begin
      if (!rstn) begin
        ack_ff <= 1'b0;
      end else begin
        ack_ff <= nxt_ack;
      end
    end

    assign lack_o[p]  = ack_ff;
    assign lack_oe[p] = rx_en;

    //////////////////////////////////////////////////////////////////////////
    // Transmit: link clock made here by division of the core clock

    logic              ack_s1_ff, ack_s2_ff;
    logic              tx_wr;
    logic [WORD_W-1:0] tx_wr_data;
    logic              tx_head_valid;
    logic [WORD_W-1:0] tx_head;
    logic              tx_take;

    always_ff @(posedge clk) begin
      if (!rstn) begin
        ack_s1_ff <= 1'b0;
        ack_s2_ff <= 1'b0;
      end else begin
        ack_s1_ff <= lack_i[p];
        ack_s2_ff <= ack_s1_ff;
      end
    end

    // Core access wins over DMA in the same cycle
    assign tx_wr      = core_wr[p] | (dma_wr[p] & dma_ok);
    assign tx_wr_data = core_wr[p] ? core_wr_data[p] : dma_wr_data[p];

    word_buffer2 #(.WIDTH(WORD_W)) u_tx_buf (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (tx_wr),
      .in_ready  (tx_ready[p]),
      .in_data   (tx_wr_data),
      .out_valid (tx_head_valid),
      .out_ready (tx_take),
      .out_data  (tx_head)
    );

    tx_state_t         st_ff,  nxt_st;
    logic [WORD_W-1:0] tsh_ff, nxt_tsh;
    logic [CNT_W-1:0]  ncnt_ff, nxt_ncnt;
    logic [TIMER_W-1:0] tmr_ff, nxt_tmr;
    logic              lclk_ff, nxt_lclk;

    always_comb begin
      nxt_st   = st_ff;
      nxt_tsh  = tsh_ff;
      nxt_ncnt = ncnt_ff;
      nxt_tmr  = tmr_ff;
      nxt_lclk = lclk_ff;
      tx_take  = 1'b0;
      case (st_ff)
        TX_IDLE: begin
          nxt_lclk = 1'b0;
          if (is_tx && tx_head_valid && ack_s2_ff) begin
            tx_take  = 1'b1;
            nxt_st   = TX_DRIVE;
            nxt_tsh  = tx_head;
            nxt_ncnt = CNT_W'(wide_word[p] ? NIBS_WIDE : NIBS_NARROW);
            nxt_tmr  = TIMER_W'(LCLK_HALF_CYC - 1);
          end
        end
        TX_DRIVE: begin
          if (tmr_ff != '0) begin
            nxt_tmr = tmr_ff - TIMER_W'(1);
          end else begin
            // Each edge strobes the nibble in place; the next one moves up on the same clock
            nxt_lclk = ~lclk_ff;
            nxt_tsh  = {{NIB_W{1'b0}}, tsh_ff[WORD_W-1:NIB_W]};
            nxt_ncnt = ncnt_ff - CNT_W'(1);
            nxt_tmr  = TIMER_W'(LCLK_HALF_CYC - 1);
            if (ncnt_ff == CNT_W'(1)) begin
              nxt_st  = TX_GAP;
              nxt_tmr = TIMER_W'(TX_GAP_CYC - 1);
            end
          end
        end
        TX_GAP: begin
          // Lets the receiver's withdrawn ack reach us before the next word
          if (tmr_ff != '0) begin
            nxt_tmr = tmr_ff - TIMER_W'(1);
          end else begin
            nxt_st = TX_IDLE;
          end
        end
        default: begin
          nxt_st = TX_IDLE;
        end
      endcase
    end

    always_ff @(posedge clk) begin
      if (!rstn) begin
        st_ff   <= TX_IDLE;
        tsh_ff  <= '0;
        ncnt_ff <= '0;
        tmr_ff  <= '0;
        lclk_ff <= 1'b0;
      end else begin
        st_ff   <= nxt_st;
        tsh_ff  <= nxt_tsh;
        ncnt_ff <= nxt_ncnt;
        tmr_ff  <= nxt_tmr;
        lclk_ff <= nxt_lclk;
      end
    end

    assign lclk_o[p]  = lclk_ff;
    assign ldat_o[p]  = tsh_ff[NIB_W-1:0];
    assign lclk_oe[p] = is_tx;
    assign ldat_oe[p] = is_tx;
  end

endmodule : nibble_link_port

// [nibble_link_port_assertions.sv]
// Purpose: Port-level checks for nibble_link_port
// Assumes: Port 0 receives and port 1 transmits in the bench
// Notes:   All watched ports sit in the core clock domain
`timescale 1ns/1ps
module nibble_link_port_assertions #(
  parameter int NPORTS = 6
) (
  input wire logic                                   clk,
  input wire logic                                   rstn,
  input wire logic [NPORTS-1:0]                      tx_mode,
  input wire logic [NPORTS-1:0]                      wide_word,
  input wire logic [NPORTS-1:0]                      lclk_o,
  input wire logic [NPORTS-1:0]                      lclk_oe,
  input wire logic [NPORTS-1:0]                      ldat_oe,
  input wire logic [NPORTS-1:0]                      lack_i,
  input wire logic [NPORTS-1:0]                      lack_o,
  input wire logic [NPORTS-1:0]                      lack_oe,
  input wire logic [NPORTS-1:0]                      rx_valid,
  input wire logic [NPORTS-1:0][link_pkg::WORD_W-1:0] rx_data,
  input wire logic [NPORTS-1:0]                      core_rd,
  input wire logic [NPORTS-1:0]                      dma_rd,
  input wire logic                                   boot_active
);
  import link_pkg::*;
  logic [5:0]        lo_cnt_ff;
  logic [5:0]        nxt_lo_cnt;
  logic [NPORTS-1:0] tx_en;
  always_comb begin
    nxt_lo_cnt = lack_i[1] ? 6'h00 : (lo_cnt_ff == 6'h3F ? lo_cnt_ff : lo_cnt_ff + 6'h01);
    tx_en = tx_mode & ~{{(NPORTS-1){1'b0}}, boot_active};
  end
  always_ff @(posedge clk) begin
    lo_cnt_ff <= rstn ? nxt_lo_cnt : 6'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  property p_clk_oe; lclk_oe == tx_en; endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock enable wrong");
  property p_dat_oe; ldat_oe == lclk_oe; endproperty
  a_dat_oe: assert property (p_dat_oe) else $error("data enable wrong");
  property p_ack_oe; lack_oe == ~lclk_oe; endproperty
  a_ack_oe: assert property (p_ack_oe) else $error("ack enable wrong");
  property p_half; $changed(lclk_o[1]) |=> $stable(lclk_o[1]); endproperty
  a_half: assert property (p_half) else $error("link clock half period");
  property p_hold;
    rx_valid[0] && !core_rd[0] && !dma_rd[0] |=> rx_valid[0] && $stable(rx_data[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("rx head lost");
  property p_narrow; rx_valid[0] && !wide_word[0] |-> rx_data[0][47:32] == 16'h0000; endproperty
  a_narrow: assert property (p_narrow) else $error("narrow word upper bits");
  // Ack falls on the edge that buffers the word, so it is low when valid rises
  property p_ack_x; $rose(rx_valid[0]) |-> !lack_o[0]; endproperty
  a_ack_x: assert property (p_ack_x) else $error("ack high while word crossing");
  // Long enough for a started wide word to finish after ack fell
  property p_stall; lo_cnt_ff >= 6'h24 |-> $stable(lclk_o[1]); endproperty
  a_stall: assert property (p_stall) else $error("sent while ack low");
  c_rx: cover property ($rose(rx_valid[0]));
  c_tx: cover property ($rose(lclk_o[1]));
  c_full: cover property (rx_valid[0] && !lack_o[0]);
endmodule : nibble_link_port_assertions
bind nibble_link_port nibble_link_port_assertions #(.NPORTS(NPORTS)) chk_inst (
  .clk, .rstn, .tx_mode, .wide_word, .lclk_o, .lclk_oe, .ldat_oe, .lack_i,
  .lack_o, .lack_oe, .rx_valid, .rx_data, .core_rd, .dma_rd, .boot_active
);

// [link_partner.sv]
// Purpose: Far link port: sends to port 0, receives from port 1
// Assumes: Own link clock of 125 ns in frames; pulses task gives 31.25 ns high pulses, 62.5 ns apart, outside them
// Notes:   Receive side samples a 1 ns delayed copy of the data
`timescale 1ns/1ps
module link_partner (
  output logic       lclk,
  output logic [3:0] ldat,
  input  wire logic  ack_in,
  input  wire logic  clk_in,
  input  wire logic [3:0] dat_in,
  output logic       ack_out,
  input  wire logic  wide,
  input  wire logic  stall
);
  logic [3:0]  dat_d;
  logic [47:0] acc;
  logic [47:0] got[$];
  int          cnt;
  assign #1 dat_d = dat_in;
  assign ack_out = ~stall;
  initial begin
    lclk = 1'b0;
    ldat = 4'h0;
  end
  // Data changes with the strobe, so the pre-edge copy is the nibble
  always @(clk_in) begin
    acc[4*cnt +: 4] = dat_d;
    cnt++;
    if (cnt == (wide ? 12 : 8)) begin
      got.push_back(acc);
      acc = 48'h0;
      cnt = 0;
    end
  end
  task automatic flush;
    acc = 48'h0;
    cnt = 0;
    got.delete();
  endtask : flush
  task automatic pulses(input int n);
    repeat (n) begin
      #31.25 lclk = 1'b1;
      #31.25 lclk = 1'b0;
    end
  endtask : pulses
  task automatic send(input logic [47:0] w, input bit wd);
    #50; // Let the receiver withdraw ack for the last word
    while (ack_in !== 1'b1) #5;
    for (int k = 0; k < (wd ? 12 : 8); k += 2) begin
      ldat = w[4*k +: 4];
      #31.25 lclk = 1'b1;
      #31.25 ldat = w[4*k+4 +: 4];
      #31.25 lclk = 1'b0;
      #31.25;
    end
    ldat = ~ldat;
  endtask : send
endmodule : link_partner

// [nibble_link_port_tb.sv]
// Purpose: Self-checking bench for nibble_link_port
// Assumes: Boot straps select a non-link source until the final boot test selects link booting
// Notes:   Port 0 receives from the partner, port 1 sends to it
`timescale 1ns/1ps
module nibble_link_port_tb;
  import link_pkg::*;
  logic                   clk, rstn, boot_active, p_clk, p_ack, stall;
  logic [5:0]             tx_mode, wide_word, core_rd, dma_rd, core_wr, dma_wr, tb_lclk;
  logic [5:0]             lclk_i, lclk_o, lclk_oe, ldat_oe, lack_i, lack_o, lack_oe;
  logic [5:0]             rx_valid, tx_ready;
  logic [5:0][NIB_W-1:0]  ldat_i, ldat_o;
  logic [5:0][WORD_W-1:0] rx_data, core_wr_data, dma_wr_data;
  logic [3:0]             p_dat;
  logic [2:0]             boot_sel;
  logic                   boot_done;
  logic [31:0]            rs, ns;
  logic [47:0]            txq[$], rxq[$];
  int                     err_count, checked;
  assign lclk_i = {tb_lclk[5:1], p_clk};
  assign ldat_i = {ns[19:0], p_dat};
  assign lack_i = {ns[3:0], p_ack, ns[4]};
  nibble_link_port nibble_link_port_inst (.clk, .rstn, .tx_mode, .wide_word, .lclk_i,
    .lclk_o, .lclk_oe, .ldat_i, .ldat_o, .ldat_oe, .lack_i, .lack_o, .lack_oe, .rx_valid,
    .rx_data, .core_rd, .dma_rd, .tx_ready, .core_wr, .core_wr_data, .dma_wr, .dma_wr_data,
    .dma_shared_grant(ns[23:20]), .link_host_boot_select(boot_sel[2]),
    .eprom_boot_select(boot_sel[1]), .boot_memory_select_n(boot_sel[0]), .boot_done,
    .boot_active);
  link_partner link_partner_inst (.lclk(p_clk), .ldat(p_dat), .ack_in(lack_o[0]),
    .clk_in(lclk_o[1]), .dat_in(ldat_o[1]), .ack_out(p_ack), .wide(wide_word[1]), .stall);
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [47:0] rw(input bit wd);
    rs = xs(rs);
    rw = {rs[31:16], rs ^ 32'hA5A5A5A5};
    if (!wd) rw[47:32] = 16'h0000;
  endfunction : rw
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      err_count++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic push(input bit dma, input bit both, input logic [47:0] w);
    bit acc;
    @(posedge clk);
    core_wr[1] <= !dma || both;
    dma_wr[1] <= dma || both;
    core_wr_data[1] <= w;
    dma_wr_data[1] <= (dma && !both) ? w : ~w;
    @(negedge clk);
    acc = tx_ready[1];
    @(posedge clk);
    core_wr[1] <= 1'b0;
    dma_wr[1] <= 1'b0;
    if (acc) txq.push_back(w);
  endtask : push
  task automatic pop(input bit dma);
    // Look off the edge, so a pop just made has settled the head word
    @(negedge clk);
    for (int n = 0; n < 2000 && rx_valid[0] !== 1'b1; n++) @(negedge clk);
    chk(rx_data[0] === rxq.pop_front(), "rx word");
    @(posedge clk);
    core_rd[0] <= !dma;
    dma_rd[0] <= dma;
    @(posedge clk);
    core_rd[0] <= 1'b0;
    dma_rd[0] <= 1'b0;
  endtask : pop
  task automatic cmp_tx;
    for (int n = 0; n < 4000 && link_partner_inst.got.size() < txq.size(); n++) @(negedge clk);
    while (txq.size() > 0) chk(link_partner_inst.got.pop_front() === txq.pop_front(), "tx");
  endtask : cmp_tx
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) ns <= xs(ns);
  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
  initial begin
    rs = 32'h0000EB73;
    ns = 32'h0000EB73;
    {rstn, core_rd, dma_rd, core_wr, dma_wr, tb_lclk, wide_word} = '0;
    core_wr_data = '0;
    dma_wr_data = '0;
    tx_mode = 6'h02;
    boot_sel = 3'h1;
    boot_done = 1'b0;
    stall = 1'b1;
    fork
      repeat (5) @(posedge clk);
      link_partner_inst.pulses(3);
      repeat (3) begin
        #31.25 tb_lclk = 6'h3E;
        #31.25 tb_lclk = 6'h00;
      end
    join
    @(negedge clk);
    chk(tx_ready === 6'h3F && rx_valid === 6'h00 && lack_o === 6'h00, "reset");
    @(posedge clk);
    rstn <= 1'b1;
    // Receive enable crosses on link clock edges only: two falls arm it
    link_partner_inst.pulses(2);
    link_partner_inst.flush();
    for (int i = 0; i < 3; i++) push(i[0], 1'b0, rw(1'b0));
    chk(txq.size() == 2 && tx_ready[1] === 1'b0, "tx fill");
    repeat (60) @(posedge clk);
    chk(link_partner_inst.got.size() == 0, "sent while ack low");
    stall <= 1'b0;
    cmp_tx();
    $display("test fill done");
    for (int wd = 0; wd < 2; wd++) begin
      @(posedge clk);
      wide_word <= {4'h0, wd[0], wd[0]};
      fork
        for (int i = 0; i < 3; i++) push(i[0], i == 0, rw(wd[0]));
        begin
          for (int i = 0; i < 2; i++) begin
            rxq.push_back(rw(wd[0]));
            link_partner_inst.send(rxq[i], wd[0]);
          end
          repeat (10) @(posedge clk);
          chk(lack_o[0] === 1'b0 && rx_valid[0] === 1'b1, "ack when full");
          rxq.push_back(rw(wd[0]));
          fork
            link_partner_inst.send(rxq[2], wd[0]);
          join_none
          for (int i = 0; i < 3; i++) pop(i[0]);
        end
      join
      cmp_tx();
      $display("test traffic done, wide %0d", wd);
    end
    @(posedge clk);
    tx_mode <= 6'h03;
    boot_sel <= 3'h5;
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(boot_active === 1'b1 && lclk_oe === 6'h02, "boot forces receive");
    @(posedge clk);
    boot_done <= 1'b1;
    @(posedge clk);
    boot_done <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(boot_active === 1'b0 && lclk_oe === 6'h03, "boot end");
    $display("test boot done");
    wrap_up();
  end
endmodule : nibble_link_port_tb
